/* File: rtl/fsa_buf2.sv */
// Two-entry valid/ready buffer for write words on their way to the array.
// Assumes both sides on clk_sys_i; full and empty are exact.
`timescale 1ns/1ns
`include "fsa_cfg.svh"

module fsa_buf2
   import fsa_pkg::*;
(
   input  wire logic    clk_sys_i,
   input  wire logic    rst_n_i,
   input  wire logic    in_valid_i,
   output logic         in_ready_o,
   input  wire fsa_wr_t in_data_i,
   output logic         out_valid_o,
   input  wire logic    out_ready_i,
   output fsa_wr_t      out_data_o
);

   fsa_wr_t    slot_q [0:`FSA_BUF_DEPTH-1];
   logic       wp_q;
   logic       wp_d;
   logic       rp_q;
   logic       rp_d;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       push;
   logic       pop;

   always_comb
   begin
      push  = in_valid_i && (cnt_q != 2'h2);
      pop   = (cnt_q != 2'h0) && out_ready_i;
      wp_d  = push ? ~wp_q : wp_q;
      rp_d  = pop ? ~rp_q : rp_q;
      cnt_d = cnt_q;
      if (push && !pop)
      begin
         cnt_d = cnt_q + 2'h1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         slot_q[wp_q] <= in_data_i;
      end
   end

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = slot_q[rp_q];

endmodule : fsa_buf2

/* File: rtl/fsa_cfg.svh */
// Constants of the two-wire memory slave: widths, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FSA_CFG_SVH
`define FSA_CFG_SVH

`define FSA_ADDR_W        11
`define FSA_DATA_W        8
`define FSA_MEM_DEPTH     2048
`define FSA_PAGE_W        3
`define FSA_TYPE_W        4
`define FSA_TYPE_HI       7
`define FSA_TYPE_LO       4
`define FSA_PAGE_HI       3
`define FSA_PAGE_LO       1
`define FSA_RW_BIT        0
`define FSA_LAST_BIT      3'h7
`define FSA_ADDR_RST      11'h000
`define FSA_ADDR_LAST     11'h7ff
`define FSA_BYTE_RST      8'h00
`define FSA_BUF_DEPTH     2
`define FSA_SCL_PERIOD_NS 125
`define FSA_CLK_PERIOD_NS 8

`endif

/* File: rtl/fsa_mem.sv */
// Single-port byte array with registered read data.
// Assumes at most one access per cycle; read data hold until the next read.
`timescale 1ns/1ns
`include "fsa_cfg.svh"

module fsa_mem
   import fsa_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   rd_en_i,
   input  wire logic                   wr_en_i,
   input  wire logic [`FSA_ADDR_W-1:0] addr_i,
   input  wire logic [`FSA_DATA_W-1:0] wdata_i,
   output logic      [`FSA_DATA_W-1:0] rdata_o
);

   logic [`FSA_DATA_W-1:0] mem [0:`FSA_MEM_DEPTH-1];
   logic [`FSA_DATA_W-1:0] rdata_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (wr_en_i)
      begin
         mem[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_q <= `FSA_BYTE_RST;
      end
      else if (rd_en_i)
      begin
         rdata_q <= mem[addr_i];
      end
   end

   assign rdata_o = rdata_q;

endmodule : fsa_mem

/* File: rtl/fsa_pkg.sv */
// Types shared by the memory slave, its write buffer and its array.
// Assumes fsa_cfg.svh is on the include path.
`include "fsa_cfg.svh"

package fsa_pkg;

   typedef enum logic [3:0] {
      S_IDLE,
      S_DEV,
      S_DEV_ACK_W,
      S_DEV_ACK_R,
      S_WORD,
      S_WORD_ACK,
      S_WDATA,
      S_COMMIT,
      S_WR_ACK,
      S_RDATA,
      S_RD_MACK
   } fsa_state_t;

   typedef struct packed {
      logic [`FSA_ADDR_W-1:0] addr;
      logic [`FSA_DATA_W-1:0] data;
   } fsa_wr_t;

endpackage : fsa_pkg

/* File: rtl/fsa_slave.sv */
// Two-wire serial slave giving byte access to a 2K x 8 nonvolatile array.
// Assumes SCL and SDA arrive from pins, asynchronous to clk_sys_i, and are
// much slower than it; the pad resolves SDA from sda_o and sda_oe_n_o.
`timescale 1ns/1ns
`include "fsa_cfg.svh"

// Operation
// (RULE1) Writes open with write address, word address
// (RULE2) Unlimited consecutive write bytes, each acknowledged
// (RULE3) Write address counter wraps 7FFh to 000h
// (RULE4) No busy period; always acknowledge addressing
// (RULE5) Commit each byte before its acknowledge
// (RULE6) Start/stop before 8th bit drops byte
// (RULE7) Protect high: no acknowledge for data
// (RULE8) Protected write leaves address counter unchanged
// (RULE9) Protect low enables writes; pulled low
// (RULE10) Read drives data next clock, page+latch
// (RULE11) Current read continues after last access
// (RULE12) Advance address per byte; ack gives next
// (RULE13) Read address wraps 7FFh to 000h
// (RULE14) Master ends read: nack then stop
// (RULE15) Master ends read: nack then start
// (RULE16) Stop in 9th clock ends read
// (RULE17) Start in 9th clock releases, re-address
// (RULE18) Master must terminate reads properly
// (RULE19) Random read: write address, start, read
// (RULE20) Start after word address keeps latch
// (RULE21) Address byte: type, page, direction
// (RULE22) Page plus word byte form 11 bits
// (RULE23) All bytes shifted MSB first
// (RULE24) Stop anywhere aborts to idle
// (RULE25) Foreign type code: no acknowledge, wait
module fsa_slave
   import fsa_pkg::*;
#(
   // Device type code; value is arbitrary
   parameter logic [`FSA_TYPE_W-1:0] DEV_TYPE = 4'h5
)
(
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_n_o,
   input  wire logic wp_i,
   output logic      wp_pull_en_o
);

   // Pin synchronisers and edge history
   logic                   scl_m_q, scl_s_q, scl_p_q;
   logic                   sda_m_q, sda_s_q, sda_p_q;
   logic                   wp_m_q, wp_s_q;

   // Bus events
   logic                   scl_rise, scl_fall, start_det, stop_det;

   // Protocol state
   fsa_state_t             state_q, state_d;
   logic [2:0]             bit_q, bit_d;
   logic                   done_q, done_d;
   logic [`FSA_DATA_W-1:0] sr_q, sr_d;
   logic [`FSA_ADDR_W-1:0] addr_q, addr_d;
   logic                   mack_q, mack_d;
   logic                   oe_n_q, oe_n_d;
   logic                   pull_q;

   // Array and buffer wiring
   logic                   rd_req, push_valid, push_ready;
   logic                   drain_valid, drain_ready, mem_wr;
   logic [`FSA_ADDR_W-1:0] rd_addr, mem_addr;
   logic [`FSA_DATA_W-1:0] rd_data;
   fsa_wr_t                push_word, drain_word;

   // Next location with wrap from the top of the array to zero
   function automatic logic [`FSA_ADDR_W-1:0] next_addr(input logic [`FSA_ADDR_W-1:0] a);
      return (a == `FSA_ADDR_LAST) ? `FSA_ADDR_RST : a + 11'h001;
   endfunction : next_addr

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         {scl_p_q, scl_s_q, scl_m_q} <= 3'h7;
         {sda_p_q, sda_s_q, sda_m_q} <= 3'h7;
         {wp_s_q, wp_m_q}            <= 2'h0;
      end
      else
      begin
         {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, scl_i};
         {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_i};
         {wp_s_q, wp_m_q}            <= {wp_m_q, wp_i};
      end
   end

   // Start and stop are SDA edges while SCL stays high
   assign scl_rise  = scl_s_q && !scl_p_q;
   assign scl_fall  = !scl_s_q && scl_p_q;
   assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

   always_comb
   begin
      state_d    = state_q;
      bit_d      = bit_q;
      done_d     = done_q;
      sr_d       = sr_q;
      addr_d     = addr_q;
      mack_d     = mack_q;
      oe_n_d     = oe_n_q;
      rd_req     = 1'b0;
      rd_addr    = addr_q;
      push_valid = 1'b0;
      push_word  = '{addr: addr_q, data: sr_q};
      if (stop_det)
      begin
         // Abandons any partial byte and read drive
         state_d = S_IDLE; // [RULE24] [RULE16] [RULE6] [RULE14]
         oe_n_d  = 1'b1;
         done_d  = 1'b0;
      end
      else if (start_det)
      begin
         // Address counter kept for the read that follows
         state_d = S_DEV; // [RULE17] [RULE20] [RULE19] [RULE6] [RULE15]
         oe_n_d  = 1'b1;
         bit_d   = 3'h0;
         done_d  = 1'b0;
      end
      else
      begin
         case (state_q)
            S_IDLE:
            begin
               oe_n_d = 1'b1;
            end
            S_DEV, S_WORD, S_WDATA:
            begin
               if (scl_rise && !done_q)
               begin
                  sr_d = {sr_q[`FSA_DATA_W-2:0], sda_s_q}; // [RULE23]
                  if (bit_q == `FSA_LAST_BIT)
                  begin
                     done_d = 1'b1;
                  end
                  else
                  begin
                     bit_d = bit_q + 3'h1;
                  end
               end
               else if (scl_fall && done_q)
               begin
                  done_d = 1'b0;
                  bit_d  = 3'h0;
                  if (state_q == S_DEV)
                  begin
                     if (sr_q[`FSA_TYPE_HI:`FSA_TYPE_LO] != DEV_TYPE)
                     begin
                        state_d = S_IDLE; // [RULE25]
                     end
                     else if (sr_q[`FSA_RW_BIT])
                     begin
                        // New page over the held low byte
                        addr_d  = {sr_q[`FSA_PAGE_HI:`FSA_PAGE_LO], addr_q[7:0]}; // [RULE10] [RULE11] [RULE21]
                        rd_req  = 1'b1;
                        rd_addr = {sr_q[`FSA_PAGE_HI:`FSA_PAGE_LO], addr_q[7:0]};
                        oe_n_d  = 1'b0; // [RULE4]
                        state_d = S_DEV_ACK_R;
                     end
                     else
                     begin
                        addr_d  = {sr_q[`FSA_PAGE_HI:`FSA_PAGE_LO], addr_q[7:0]}; // [RULE21] [RULE1]
                        oe_n_d  = 1'b0; // [RULE4]
                        state_d = S_DEV_ACK_W;
                     end
                  end
                  else if (state_q == S_WORD)
                  begin
                     addr_d  = {addr_q[`FSA_ADDR_W-1:8], sr_q}; // [RULE22] [RULE19]
                     oe_n_d  = 1'b0;
                     state_d = S_WORD_ACK;
                  end
                  else if (wp_s_q)
                  begin
                     // Protected: no acknowledge, counter held
                     state_d = S_IDLE; // [RULE7] [RULE8]
                  end
                  else
                  begin
                     state_d = S_COMMIT; // [RULE9]
                  end
               end
            end
            S_COMMIT:
            begin
               // Ack waits until the byte is taken by the array path
               push_valid = 1'b1; // [RULE5]
               if (push_ready)
               begin
                  addr_d  = next_addr(addr_q); // [RULE3] [RULE2]
                  oe_n_d  = 1'b0;
                  state_d = S_WR_ACK;
               end
            end
            S_DEV_ACK_W, S_WORD_ACK, S_WR_ACK:
            begin
               if (scl_fall)
               begin
                  oe_n_d  = 1'b1;
                  bit_d   = 3'h0;
                  state_d = (state_q == S_DEV_ACK_W) ? S_WORD : S_WDATA;
               end
            end
            S_DEV_ACK_R:
            begin
               if (scl_fall)
               begin
                  sr_d    = rd_data; // [RULE10]
                  oe_n_d  = rd_data[`FSA_DATA_W-1];
                  addr_d  = next_addr(addr_q); // [RULE12] [RULE13]
                  bit_d   = 3'h0;
                  state_d = S_RDATA;
               end
            end
            S_RDATA:
            begin
               if (scl_fall)
               begin
                  if (bit_q == `FSA_LAST_BIT)
                  begin
                     // Release for the master's acknowledge, fetch next byte
                     oe_n_d  = 1'b1;
                     rd_req  = 1'b1;
                     rd_addr = addr_q;
                     mack_d  = 1'b0;
                     state_d = S_RD_MACK;
                  end
                  else
                  begin
                     sr_d   = {sr_q[`FSA_DATA_W-2:0], 1'b0}; // [RULE23]
                     oe_n_d = sr_q[`FSA_DATA_W-2];
                     bit_d  = bit_q + 3'h1;
                  end
               end
            end
            S_RD_MACK:
            begin
               if (scl_rise)
               begin
                  mack_d = !sda_s_q;
               end
               else if (scl_fall)
               begin
                  if (mack_q)
                  begin
                     sr_d    = rd_data; // [RULE12]
                     oe_n_d  = rd_data[`FSA_DATA_W-1];
                     addr_d  = next_addr(addr_q); // [RULE13]
                     bit_d   = 3'h0;
                     state_d = S_RDATA;
                  end
                  else
                  begin
                     // No acknowledge ends the read, bus released
                     state_d = S_IDLE; // [RULE14] [RULE15] [RULE18]
                  end
               end
            end
            default:
            begin
               state_d = S_IDLE;
               oe_n_d  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= S_IDLE;
         bit_q   <= 3'h0;
         done_q  <= 1'b0;
         sr_q    <= `FSA_BYTE_RST;
         addr_q  <= `FSA_ADDR_RST;
         mack_q  <= 1'b0;
         oe_n_q  <= 1'b1;
         pull_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         bit_q   <= bit_d;
         done_q  <= done_d;
         sr_q    <= sr_d;
         addr_q  <= addr_d;
         mack_q  <= mack_d;
         oe_n_q  <= oe_n_d;
         pull_q  <= 1'b1; // [RULE9]
      end
   end

   // Reads take the single array port first; draining waits a cycle
   assign drain_ready = !rd_req;
   assign mem_wr      = drain_valid && drain_ready;
   assign mem_addr    = rd_req ? rd_addr : drain_word.addr;

   fsa_buf2 u_buf
   (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .in_data_i   (push_word),
      .out_valid_o (drain_valid),
      .out_ready_i (drain_ready),
      .out_data_o  (drain_word)
   );

   fsa_mem u_mem
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .rd_en_i   (rd_req),
      .wr_en_i   (mem_wr),
      .addr_i    (mem_addr),
      .wdata_i   (drain_word.data),
      .rdata_o   (rd_data)
   );

   // Open drain: output value fixed low, enable low while pulling
   assign sda_o        = 1'b0;
   assign sda_oe_n_o   = oe_n_q;
   assign wp_pull_en_o = pull_q;

endmodule : fsa_slave

/* File: tb/fsa_master_model.sv */
// Two-wire bus master model: drives SCL, pulls SDA low through an enable.
// Assumes the bench resolves SDA with a pull-up from all enables.
`timescale 1ns/1ns
module fsa_master_model
(
   output logic      scl_o,
   output logic      sda_oe_n_o,
   input  wire logic sda_i
);
   localparam int Q = 31;
   initial
   begin
      scl_o      = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   // One 125 ns bit cell; SDA moves only while SCL is low
   task automatic bit_cell(input logic b, output logic s);
      #Q sda_oe_n_o = b;
      #Q scl_o = 1'b1;
      #Q s = sda_i;
      #(Q + 1) scl_o = 1'b0;
   endtask : bit_cell
   task automatic start_c();
      #Q sda_oe_n_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_oe_n_o = 1'b0;
      #(Q + 1) scl_o = 1'b0;
   endtask : start_c
   // Clock stands high after the stop
   task automatic stop_c();
      #Q sda_oe_n_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_oe_n_o = 1'b1;
      #(Q + 1);
   endtask : stop_c
   // MSB first; fewer than 8 bits leaves the byte open for an abort
   task automatic put_byte(input logic [7:0] b, input int n, output logic ack);
      logic s;
      ack = 1'b1;
      for (int i = 0; i < n; i++)
         bit_cell(b[7 - i], s);
      if (n == 8)
         bit_cell(1'b1, ack);
   endtask : put_byte
   task automatic get_byte(input logic mack, input logic ninth, output logic [7:0] d);
      logic s;
      for (int i = 0; i < 8; i++)
         bit_cell(1'b1, d[7 - i]);
      if (ninth)
         bit_cell(!mack, s);
   endtask : get_byte
endmodule : fsa_master_model

/* File: tb/fsa_slave_asserts.sv */
// Checker for the two-wire memory slave, bound to its ports.
// Assumes raw SCL and SDA are slow against clk_sys_i.
`timescale 1ns/1ns
module fsa_slave_asserts
   import fsa_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'h5
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic wp_i,
   input wire logic wp_pull_en_o
);
   logic       scl_q, sda_q, scl_d, sda_d, st, mt;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   // Bus decode: bit count since START and the slave address byte
   always_comb
   begin
      st    = scl_i && scl_q && sda_q && !sda_i;
      mt    = sh_q[7:4] == DEV_TYPE;
      scl_d = scl_i;
      sda_d = sda_i;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      if (st)
      begin
         cnt_d = 5'h00;
      end
      else if (scl_i && !scl_q && cnt_q != 5'h1f)
      begin
         cnt_d = cnt_q + 5'h01;
         sh_d  = (cnt_q < 5'h08) ? {sh_q[6:0], sda_i} : sh_q;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         {scl_q, sda_q, cnt_q, sh_q} <= {2'h3, 5'h1f, 8'h00};
      end
      else
      begin
         {scl_q, sda_q, cnt_q, sh_q} <= {scl_d, sda_d, cnt_d, sh_d};
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   a_pull_hold: assert property (
      rst_n_i && $past(rst_n_i) |-> wp_pull_en_o) else $error("wp pull-down not requested");
   a_drive_scl_low: assert property (
      $changed(sda_oe_n_o) |-> !scl_i) else $error("data drive changed while clock high");
   a_addr_ack: assert property (
      $fell(scl_i) && cnt_q == 5'd8 && mt |-> ##[1:8] !sda_oe_n_o) else $error("address not acknowledged");
   a_word_ack: assert property (
      $fell(scl_i) && cnt_q == 5'd17 && mt && !sh_q[0] |-> ##[1:8] !sda_oe_n_o) else $error("word not acknowledged");
   a_data_ack: assert property (
      $fell(scl_i) && cnt_q == 5'd26 && mt && !sh_q[0] && !wp_i && !$past(wp_i, 8)
      |-> ##[1:8] !sda_oe_n_o) else $error("data byte not acknowledged");
   a_protect_nack: assert property (
      $fell(scl_i) && cnt_q == 5'd26 && mt && !sh_q[0] && wp_i && $past(wp_i, 8)
      |-> sda_oe_n_o [*8]) else $error("protected byte acknowledged");
   a_read_release: assert property (
      $fell(scl_i) && cnt_q == 5'd17 && mt && sh_q[0] |-> ##6 sda_oe_n_o [*2]) else $error("no release for ack");
   a_stop_release: assert property (
      scl_i && scl_q && !sda_q && sda_i |=> sda_oe_n_o [*8]) else $error("data driven after stop");
   a_foreign_silent: assert property (
      cnt_q >= 5'h08 && !mt |-> sda_oe_n_o) else $error("foreign address answered");
   c_write: cover property (cnt_q == 5'd26 && !sda_oe_n_o);
   c_protect: cover property (cnt_q == 5'd26 && wp_i);
   c_foreign: cover property (cnt_q == 5'd8 && !mt);
endmodule : fsa_slave_asserts

bind fsa_slave fsa_slave_asserts #(.DEV_TYPE(DEV_TYPE)) u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i), .wp_pull_en_o(wp_pull_en_o));

/* File: tb/tb_top.sv */
// Testbench for the two-wire memory slave against a bus master model.
// Assumes the checker is bound to the slave from its own file.
`timescale 1ns/1ns
module tb_top;
   import fsa_pkg::*;
   // Device type code; value is arbitrary
   localparam logic [3:0] DT = 4'h5;
   logic       clk_sys_i, rst_n_i, wp_i, sda_o, sda_oe_n_o, wp_pull_en_o, m_oe_n, scl, a;
   wire        sda;
   logic [7:0] d;
   int         fails;
   int         n_tests;
   // Open-drain bus with pull-up
   assign sda = m_oe_n & (sda_oe_n_o | sda_o);
   fsa_slave #(.DEV_TYPE(DT)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i), .wp_pull_en_o(wp_pull_en_o));
   fsa_master_model m (.scl_o(scl), .sda_oe_n_o(m_oe_n), .sda_i(sda));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic sel(input logic [2:0] pg, input logic rw);
      m.start_c();
      m.put_byte({DT, pg, rw}, 8, a);
      chk("addr ack", {7'h00, a}, 8'h00);
   endtask : sel
   task automatic put(input logic [7:0] b);
      m.put_byte(b, 8, a);
      chk("write ack", {7'h00, a}, 8'h00);
   endtask : put
   task automatic get(input logic mack, input logic [7:0] exp);
      m.get_byte(mack, 1'b1, d);
      chk("read data", d, exp);
   endtask : get
   // Writes run across 7FFh into 000h
   task automatic t_write_wrap();
      sel(3'h7, 1'b0);
      put(8'hfe);
      for (int i = 0; i < 4; i++)
         put(8'h10 + 8'(i));
      m.stop_c();
   endtask : t_write_wrap
   // Random read across the wrap, then a current read on another page
   task automatic t_random_read();
      sel(3'h7, 1'b0);
      put(8'hfe);
      sel(3'h7, 1'b1);
      get(1'b1, 8'h10);
      get(1'b1, 8'h11);
      get(1'b0, 8'h12);
      sel(3'h0, 1'b1);
      get(1'b0, 8'h13);
   endtask : t_random_read
   // Bytes cut short by stop and by start leave the array alone
   task automatic t_abort();
      sel(3'h0, 1'b0);
      put(8'h20);
      put(8'h55);
      m.stop_c();
      sel(3'h0, 1'b0);
      put(8'h20);
      m.put_byte(8'haa, 5, a);
      m.stop_c();
      sel(3'h0, 1'b0);
      put(8'h20);
      m.put_byte(8'hcc, 3, a);
      sel(3'h0, 1'b0);
      put(8'h20);
      sel(3'h0, 1'b1);
      get(1'b0, 8'h55);
      m.stop_c();
   endtask : t_abort
   task automatic t_protect();
      sel(3'h0, 1'b0);
      put(8'h30);
      put(8'h77);
      m.stop_c();
      @(posedge clk_sys_i) wp_i <= 1'b1;
      sel(3'h0, 1'b0);
      put(8'h30);
      m.put_byte(8'h66, 8, a);
      chk("protect nack", {7'h00, a}, 8'h01);
      m.stop_c();
      @(posedge clk_sys_i) wp_i <= 1'b0;
      chk("wp pull", {7'h00, wp_pull_en_o}, 8'h01);
      sel(3'h0, 1'b1);
      get(1'b0, 8'h77);
      m.stop_c();
   endtask : t_protect
   task automatic t_foreign();
      m.start_c();
      m.put_byte({DT ^ 4'h3, 4'h0}, 8, a);
      chk("foreign ack", {7'h00, a}, 8'h01);
      m.put_byte(8'h00, 8, a);
      chk("foreign byte", {7'h00, a}, 8'h01);
      m.stop_c();
   endtask : t_foreign
   // Stop, then start, in the ninth clock of a read
   task automatic t_read_end();
      sel(3'h7, 1'b0);
      put(8'hfe);
      sel(3'h7, 1'b1);
      m.get_byte(1'b0, 1'b0, d);
      chk("read data", d, 8'h10);
      m.stop_c();
      chk("released", {7'h00, sda_oe_n_o}, 8'h01);
      sel(3'h7, 1'b0);
      put(8'hfe);
      sel(3'h7, 1'b1);
      m.get_byte(1'b0, 1'b0, d);
      chk("read data", d, 8'h10);
      sel(3'h7, 1'b1);
      get(1'b0, 8'h11);
      m.stop_c();
   endtask : t_read_end
   initial
   begin
      rst_n_i = 1'b0;
      wp_i    = 1'b0;
      fails   = 0;
      n_tests = 0;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      t_write_wrap();
      t_random_read();
      t_abort();
      t_protect();
      t_foreign();
      t_read_end();
      final_report();
   end
   initial
   begin
      repeat (60000) @(posedge clk_sys_i);
      fails++;
      final_report();
   end
endmodule : tb_top
